// ---- dv/ucs_ctrl_monitor.sv ----
`timescale 1ns/100ps
module ucs_mon
   import ucs_pkg::*;
(
   // clock and reset
   input wire logic             aclk,
   input wire logic             aresetn,
   // bus handshakes
   input wire logic             s_axi_awvalid,
   input wire logic             s_axi_awready,
   input wire logic             s_axi_wvalid,
   input wire logic             s_axi_wready,
   input wire logic             s_axi_bvalid,
   input wire logic             s_axi_bready,
   input wire logic             s_axi_arvalid,
   input wire logic             s_axi_arready,
   input wire logic             s_axi_rvalid,
   input wire logic             s_axi_rready,
   // sequencer
   input wire logic [IDX_W-1:0] active_idx,
   input wire logic             busy
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_rfin;
      s_axi_rvalid && s_axi_rready;
   endsequence
   property p_step;
      !$stable(active_idx) |-> active_idx == '0 || active_idx == IDX_W'($past(active_idx) + 1);
   endproperty
   AST_RD_ANSWER: assert property (s_rd |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   AST_RD_RELEASE: assert property (s_rfin |=> !s_axi_rvalid && s_axi_arready)
      else $error("read not released");
   AST_WR_HOLDOFF: assert property (s_wr |=> !s_axi_awready && !s_axi_wready)
      else $error("write taken during execution");
   AST_WR_ANSWER: assert property (s_wr |-> ##[1:80] s_axi_bvalid)
      else $error("write answer late");
   AST_B_RELEASE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not released");
   AST_IDX_STEP: assert property (p_step)
      else $error("active index jumped");
   AST_BUSY_FREEZE: assert property (busy |=> $stable(active_idx) || active_idx == '0)
      else $error("index moved while busy");
   AST_BOOT: assert property ($rose(aresetn) |-> ##[1:60] !busy)
      else $error("restore after reset too slow");
endmodule : ucs_mon

bind ucs_ctrl ucs_mon i_mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .active_idx, .busy);

// ---- dv/ucs_trig_src.sv ----
`timescale 1ns/100ps
module ucs_trig_src (
   // clock and request
   input wire logic aclk,
   input wire logic fire,
   // trigger pin
   output logic     frame_trig
);
   // held long enough for the input synchroniser to see one rising edge
   initial frame_trig = 1'b0;
   always @(posedge aclk) begin
      if (fire) begin
         frame_trig <= 1'b1;
         repeat (8) @(posedge aclk);
         frame_trig <= 1'b0;
      end
   end
endmodule : ucs_trig_src

// ---- dv/user_set_and_sequencer_control_tb_top.sv ----
`timescale 1ns/100ps
module user_set_and_sequencer_control_tb_top;
   import ucs_pkg::*;
   logic aclk = 0, aresetn = 0, fire = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, frame_trig, busy;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, seed = 32'd72340;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [4:0]  active_idx;
   logic [3:0]  ffc_loc;
   int          fails = 0, total_checks = 0, idx = 0, cnt = 4, tab[32];
   localparam logic [7:0] BAD_A [8] = '{OFS_LOAD, OFS_SAVE, OFS_SAVE, OFS_DFLT, OFS_COUNT,
                                        OFS_COUNT, OFS_SET_SEL, OFS_SEQ_EN};
   localparam int         BAD_V [8] = '{3, 0, 3, 3, 0, 33, 32, 2};
   always #4 aclk = ~aclk;
   ucs_ctrl i_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
      .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
      .s_axi_rresp, .frame_trig, .active_idx, .ffc_loc, .busy);
   ucs_trig_src i_src (.aclk, .fire, .frame_trig);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ad = 1'b0;
      logic wd = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (!ad && s_axi_awready) begin
            ad = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!wd && s_axi_wready) begin
            wd = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      chk(s_axi_bresp, er);
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      chk(s_axi_rdata, exp);
      chk(s_axi_rresp, (a == 8'h40) ? RESP_DECERR : RESP_OKAY);
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : rchk
   task automatic trig();
      fire <= 1'b1;
      @(posedge aclk);
      fire <= 1'b0;
      repeat (24) @(posedge aclk);
      idx = (idx + 1) % cnt;
      chk(active_idx, idx);
      chk(ffc_loc, tab[idx]);
   endtask : trig
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   initial begin
      repeat (20000) @(posedge aclk);
      fails++;
      complete_run();
   end
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      while (busy) @(posedge aclk);
      rchk(OFS_COUNT, 1);
      wr(OFS_SEQ_EN, 0, RESP_OKAY);
      wr(OFS_CFG, 1, RESP_OKAY);
      for (int i = 0; i < 32; i++) begin
         tab[i] = rnd() & 15;
         wr(OFS_SET_SEL, i, RESP_OKAY);
         wr(OFS_FFC_SEL, tab[i], RESP_OKAY);
      end
      rchk(OFS_FFC_SEL, tab[31]);
      wr(OFS_COUNT, cnt, RESP_OKAY);
      wr(OFS_CFG, 0, RESP_OKAY);
      wr(OFS_TRIG_MODE, 1, RESP_OKAY);
      wr(OFS_SEQ_EN, 1, RESP_OKAY);
      for (int i = 0; i < 6; i++) trig();
      rchk(OFS_ACTIVE, idx);
      wr(OFS_RESTART, 0, RESP_OKAY);
      idx = 0;
      rchk(OFS_ACTIVE, 0);
      for (int i = 0; i < 8; i++) begin
         wr(BAD_A[i], BAD_V[i], RESP_SLVERR);
         rchk(OFS_ERROR, ERR_BAD_PARAM);
      end
      rchk(OFS_COUNT, cnt);
      wr(8'h40, 0, RESP_DECERR);
      rchk(8'h40, 0);
      wr(OFS_SAVE, 1, RESP_OKAY);
      wr(OFS_DFLT, 1, RESP_OKAY);
      wr(OFS_COUNT, 32, RESP_OKAY);
      cnt = 32;
      trig();
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      while (busy) @(posedge aclk);
      cnt = 4;
      idx = 0;
      rchk(OFS_COUNT, 4);
      trig();
      wr(OFS_LOAD, 0, RESP_OKAY);
      rchk(OFS_COUNT, 1);
      wr(OFS_LOAD, 1, RESP_OKAY);
      rchk(OFS_COUNT, 4);
      // free run: a trigger must leave the set in effect alone
      wr(OFS_TRIG_MODE, 0, RESP_OKAY);
      fire <= 1'b1;
      @(posedge aclk);
      fire <= 1'b0;
      repeat (24) @(posedge aclk);
      chk(active_idx, 0);
      chk(ffc_loc, tab[0]);
      wr(OFS_LOAD, 2, RESP_OKAY);
      rchk(OFS_COUNT, 1);
      rchk(OFS_DFLT, 1);
      complete_run();
   end
endmodule : user_set_and_sequencer_control_tb_top

// ---- hw/ucs_ctrl.sv ----
`timescale 1ns/100ps
module ucs_ctrl
   import ucs_pkg::*;
(
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // axi4-lite write address
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   // axi4-lite write data
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   // axi4-lite write response
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   output logic [1:0]             s_axi_bresp,
   // axi4-lite read address
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   // axi4-lite read data
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   // acquisition
   input  wire logic              frame_trig,
   output logic [IDX_W-1:0]       active_idx,
   output logic [FFC_W-1:0]       ffc_loc,
   output logic                   busy
);
   ucs_store_if st ();

   ucs_store u_store (
      .aclk (aclk),
      .st   (st.store)
   );

   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      case (a)
         OFS_LOAD, OFS_SAVE, OFS_DFLT, OFS_SEQ_EN, OFS_CFG, OFS_SET_SEL, OFS_FFC_SEL,
         OFS_COUNT, OFS_RESTART, OFS_ACTIVE, OFS_STATUS, OFS_ERROR,
         OFS_TRIG_MODE: is_mapped = 1'b1;
         default:       is_mapped = 1'b0;
      endcase
   endfunction : is_mapped

   function automatic logic [ENTRY_W-1:0] pack_hdr(input logic trig, input logic en,
                                                   input logic [IDX_W-1:0] cm1,
                                                   input logic [FFC_W-1:0] ffc);
      pack_hdr = {trig, en, cm1, ffc};
   endfunction : pack_hdr

   // state
   ucs_state_t         state,   next_state;
   logic [5:0]         cp_idx,  next_cp_idx;
   logic [1:0]         cp_slot, next_cp_slot;
   logic               resp_wait, next_resp_wait;
   logic               dflt_we, next_dflt_we;
   logic [1:0]         dflt_wd, next_dflt_wd;
   // working settings, volatile
   logic [FFC_W-1:0]   tbl [NUM_SETS];
   logic [FFC_W-1:0]   next_tbl [NUM_SETS];
   logic               seq_en,  next_seq_en;
   logic               cfg,     next_cfg;
   logic               trig_md, next_trig_md;
   logic [IDX_W-1:0]   set_sel, next_set_sel;
   logic [IDX_W-1:0]   cnt_m1,  next_cnt_m1;
   logic [FFC_W-1:0]   ffc_sel, next_ffc_sel;
   logic [IDX_W-1:0]   active,  next_active;
   logic [31:0]        last_err, next_last_err;
   // bus
   logic               aw_hold, next_aw_hold;
   logic [ADDR_W-1:0]  aw_addr, next_aw_addr;
   logic               w_hold,  next_w_hold;
   logic [31:0]        w_data,  next_w_data;
   logic [3:0]         w_strb,  next_w_strb;
   logic               next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0]         next_bresp, next_rresp;
   logic [31:0]        next_rdata;
   logic [FFC_W-1:0]   next_ffc_loc;
   // trigger synchroniser
   logic               trig_s1, trig_s2, trig_s3, trig_lvl, next_trig_lvl;
   logic               trig_rise;

   assign st.slot       = cp_slot;
   assign st.idx        = cp_idx;
   assign st.we         = (state == ST_SAVE);
   assign st.wdata      = (cp_idx == HDR_IDX) ? pack_hdr(trig_md, seq_en, cnt_m1, ffc_sel)
                                              : {7'h00, tbl[cp_idx[IDX_W-1:0]]};
   assign st.dflt_we    = dflt_we;
   assign st.dflt_wdata = dflt_wd;

   always_comb begin
      logic            exec;
      logic [31:0]     v;
      logic            ok;
      exec = 1'b0;
      v    = 32'h0000_0000;
      ok   = 1'b1;
      next_state     = state;
      next_cp_idx    = cp_idx;
      next_cp_slot   = cp_slot;
      next_resp_wait = resp_wait;
      next_dflt_we   = 1'b0;
      next_dflt_wd   = dflt_wd;
      next_tbl       = tbl;
      next_seq_en    = seq_en;
      next_cfg       = cfg;
      next_trig_md   = trig_md;
      next_set_sel   = set_sel;
      next_cnt_m1    = cnt_m1;
      next_ffc_sel   = ffc_sel;
      next_active    = active;
      next_last_err  = last_err;
      next_aw_hold   = aw_hold;
      next_aw_addr   = aw_addr;
      next_w_hold    = w_hold;
      next_w_data    = w_data;
      next_w_strb    = w_strb;
      next_bvalid    = s_axi_bvalid;
      next_bresp     = s_axi_bresp;
      next_arready   = !s_axi_rvalid; // free again once no read answer stands
      next_rvalid    = s_axi_rvalid;
      next_rdata     = s_axi_rdata;
      next_rresp     = s_axi_rresp;
      next_trig_lvl  = trig_lvl;
      trig_rise      = 1'b0;

      // a level change counts once the two later stages agree
      if (trig_s2 == trig_s3 && trig_s3 != trig_lvl) begin
         next_trig_lvl = trig_s3;
         trig_rise     = trig_s3;
      end

      // copy engine between working settings and a slot
      case (state)
         ST_BOOT: begin
            next_cp_slot = st.dflt_sel;
            next_cp_idx  = 6'h00;
            next_state   = ST_LOAD;
         end
         ST_LOAD: begin
            if (cp_idx == HDR_IDX) begin
               next_ffc_sel = st.rdata[HDR_FFC_LSB +: FFC_W];
               next_cnt_m1  = st.rdata[HDR_CNT_LSB +: IDX_W];
               next_seq_en  = st.rdata[HDR_EN_BIT];
               next_trig_md = st.rdata[HDR_TRIG_BIT];
               next_active  = '0;
               next_state   = ST_IDLE;
            end else begin
               next_tbl[cp_idx[IDX_W-1:0]] = st.rdata[FFC_W-1:0];
               next_cp_idx = cp_idx + 6'h01;
            end
         end
         ST_SAVE: begin
            if (cp_idx == HDR_IDX) begin
               next_state = ST_IDLE;
            end else begin
               next_cp_idx = cp_idx + 6'h01;
            end
         end
         ST_IDLE: begin
            if (trig_rise && seq_en && trig_md) begin
               next_active = (active >= cnt_m1) ? '0 : active + 5'h01;
            end
         end
         default: next_state = ST_BOOT;
      endcase

      // answer a copy command only once the copy is done
      if (resp_wait && state != ST_IDLE && next_state == ST_IDLE) begin
         next_resp_wait = 1'b0;
         next_bvalid    = 1'b1;
         next_bresp     = RESP_OKAY;
      end

      // write channel capture, either order
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_hold = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_hold = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end

      // commands are held off while a copy runs
      exec = aw_hold && w_hold && state == ST_IDLE && !resp_wait && !s_axi_bvalid;
      if (exec) begin
         next_aw_hold = 1'b0;
         next_w_hold  = 1'b0;
         v            = w_data;
         next_bvalid  = 1'b1;
         next_bresp   = RESP_OKAY;
         if (!is_mapped(aw_addr)) begin
            next_bresp = RESP_DECERR;
         end else if (w_strb[0]) begin
            case (aw_addr)
               OFS_LOAD: begin
                  ok = (v <= 32'(SLOT_USER2));
                  if (ok) begin
                     next_cp_slot   = v[1:0];
                     next_cp_idx    = 6'h00;
                     next_state     = ST_LOAD;
                  end
               end
               OFS_SAVE: begin
                  ok = (v == 32'(SLOT_USER1)) || (v == 32'(SLOT_USER2));
                  if (ok) begin
                     next_cp_slot   = v[1:0];
                     next_cp_idx    = 6'h00;
                     next_state     = ST_SAVE;
                  end
               end
               OFS_DFLT: begin
                  ok = (v <= 32'(SLOT_USER2));
                  if (ok) begin
                     next_dflt_we = 1'b1;
                     next_dflt_wd = v[1:0];
                  end
               end
               OFS_SEQ_EN: begin
                  ok = (v <= 32'h0000_0001);
                  if (ok) begin
                     next_seq_en = v[0];
                  end
               end
               OFS_CFG: begin
                  ok = (v <= 32'h0000_0001);
                  if (ok) begin
                     next_cfg = v[0];
                  end
               end
               OFS_TRIG_MODE: begin
                  ok = (v <= 32'h0000_0001);
                  if (ok) begin
                     next_trig_md = v[0];
                  end
               end
               OFS_SET_SEL: begin
                  ok = (v < 32'(NUM_SETS));
                  if (ok) begin
                     next_set_sel = v[IDX_W-1:0];
                  end
               end
               OFS_FFC_SEL: begin
                  ok = (v <= 32'(FFC_MAX));
                  if (ok) begin
                     next_ffc_sel = v[FFC_W-1:0];
                     if (cfg) begin
                        next_tbl[set_sel] = v[FFC_W-1:0];
                     end
                  end
               end
               OFS_COUNT: begin
                  ok = (v >= 32'(COUNT_MIN)) && (v <= 32'(COUNT_MAX));
                  if (ok) begin
                     next_cnt_m1 = 5'(v - 32'h0000_0001);
                     next_active = '0;
                  end
               end
               OFS_RESTART: begin
                  next_active = '0;
               end
               default: ok = 1'b0;
            endcase
            if (!ok) begin
               next_bresp    = RESP_SLVERR;
               next_last_err = ERR_BAD_PARAM;
            end else begin
               next_last_err = ERR_NONE;
               if (next_state == ST_LOAD || next_state == ST_SAVE) begin
                  next_bvalid    = 1'b0;
                  next_resp_wait = 1'b1;
               end
            end
         end
      end
      next_awready = !next_aw_hold;
      next_wready  = !next_w_hold;

      // read channel
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid  = 1'b0;
         next_arready = 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_arready = 1'b0;
         next_rvalid  = 1'b1;
         next_rresp   = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
         case (s_axi_araddr)
            OFS_DFLT:      next_rdata = {30'h0000_0000, st.dflt_sel};
            OFS_SEQ_EN:    next_rdata = {31'h0000_0000, seq_en};
            OFS_CFG:       next_rdata = {31'h0000_0000, cfg};
            OFS_TRIG_MODE: next_rdata = {31'h0000_0000, trig_md};
            OFS_SET_SEL:   next_rdata = {27'h000_0000, set_sel};
            OFS_FFC_SEL:   next_rdata = {28'h000_0000, cfg ? tbl[set_sel] : ffc_sel};
            OFS_COUNT:     next_rdata = {27'h000_0000, cnt_m1} + 32'h0000_0001;
            OFS_ACTIVE:    next_rdata = {27'h000_0000, active};
            OFS_STATUS:    next_rdata = {31'h0000_0000, state != ST_IDLE};
            OFS_ERROR:     next_rdata = last_err;
            default:       next_rdata = 32'h0000_0000;
         endcase
      end

      // the set in effect drives the correction datapath
      next_ffc_loc = next_seq_en ? next_tbl[next_active] : next_ffc_sel;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state         <= ST_BOOT;
         cp_idx        <= 6'h00;
         cp_slot       <= SLOT_FACTORY;
         resp_wait     <= 1'b0;
         dflt_we       <= 1'b0;
         dflt_wd       <= RST_DFLT;
         tbl           <= '{default: FACTORY_FFC};
         seq_en        <= 1'b0;
         cfg           <= 1'b0;
         trig_md       <= 1'b0;
         set_sel       <= '0;
         cnt_m1        <= '0;
         ffc_sel       <= FACTORY_FFC;
         active        <= '0;
         last_err      <= ERR_NONE;
         aw_hold       <= 1'b0;
         aw_addr       <= '0;
         w_hold        <= 1'b0;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
         trig_s1       <= 1'b0;
         trig_s2       <= 1'b0;
         trig_s3       <= 1'b0;
         trig_lvl      <= 1'b0;
         active_idx    <= '0;
         ffc_loc       <= FACTORY_FFC;
         busy          <= 1'b1;
      end else begin
         state         <= next_state;
         cp_idx        <= next_cp_idx;
         cp_slot       <= next_cp_slot;
         resp_wait     <= next_resp_wait;
         dflt_we       <= next_dflt_we;
         dflt_wd       <= next_dflt_wd;
         tbl           <= next_tbl;
         seq_en        <= next_seq_en;
         cfg           <= next_cfg;
         trig_md       <= next_trig_md;
         set_sel       <= next_set_sel;
         cnt_m1        <= next_cnt_m1;
         ffc_sel       <= next_ffc_sel;
         active        <= next_active;
         last_err      <= next_last_err;
         aw_hold       <= next_aw_hold;
         aw_addr       <= next_aw_addr;
         w_hold        <= next_w_hold;
         w_data        <= next_w_data;
         w_strb        <= next_w_strb;
         s_axi_awready <= next_awready;
         s_axi_wready  <= next_wready;
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid  <= next_rvalid;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
         trig_s1       <= frame_trig;
         trig_s2       <= trig_s1;
         trig_s3       <= trig_s2;
         trig_lvl      <= next_trig_lvl;
         active_idx    <= next_active;
         ffc_loc       <= next_ffc_loc;
         busy          <= (next_state != ST_IDLE);
      end
   end
endmodule : ucs_ctrl

// ---- hw/ucs_pkg.sv ----
// Functional notes
// - two writable user slots; factory plus both user slots loadable, all nonvolatile
// - load command: 0 factory, 1 user one, 2 user two into working settings
// - save command: whole working settings into user one (1) or user two (2)
// - reset-default selector 0/1/2 picks the slot applied after every reset
// - factory settings loadable but never overwritten by a save
// - working settings volatile; reset restarts from the selected default slot
// - sequencer sets saved with user slots and restored after reset
// - sequencing enabled with trigger mode 1: successive triggered acquisitions get successive sets; free run keeps the set
// - up to 32 sequencer sets, indices 0 through 31
// - each set holds only a flat-field data location
// - sequencing enable: 0 off, 1 on
// - config mode on: written flat-field location goes into the selected set
// - set selector holds the index being configured
// - active set index 0..31 readable on request
// - set count 1..32 sets how many sets, from index 0, are cycled
// - restart command makes set 0 active at any moment
// - control channel 115200 bps, 8N1, no flow control; commands arrive over the AXI4-lite register bus instead
// - each command answered, then ready for the next one
// - out-of-range parameter rejected with invalid-parameter code, settings kept
package ucs_pkg;
   localparam int          ADDR_W        = 8;
   // register byte offsets
   localparam logic [7:0]  OFS_LOAD      = 8'h00;
   localparam logic [7:0]  OFS_SAVE      = 8'h04;
   localparam logic [7:0]  OFS_DFLT      = 8'h08;
   localparam logic [7:0]  OFS_SEQ_EN    = 8'h0C;
   localparam logic [7:0]  OFS_CFG       = 8'h10;
   localparam logic [7:0]  OFS_SET_SEL   = 8'h14;
   localparam logic [7:0]  OFS_FFC_SEL   = 8'h18;
   localparam logic [7:0]  OFS_COUNT     = 8'h1C;
   localparam logic [7:0]  OFS_RESTART   = 8'h20;
   localparam logic [7:0]  OFS_ACTIVE    = 8'h24;
   localparam logic [7:0]  OFS_STATUS    = 8'h28;
   localparam logic [7:0]  OFS_ERROR     = 8'h2C;
   localparam logic [7:0]  OFS_TRIG_MODE = 8'h30;
   // bus answers
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   localparam logic [1:0]  RESP_DECERR   = 2'h3;
   localparam logic [31:0] ERR_NONE      = 32'h0000_0000;
   localparam logic [31:0] ERR_BAD_PARAM = 32'h8000_0481;
   // slots
   localparam logic [1:0]  SLOT_FACTORY  = 2'h0;
   localparam logic [1:0]  SLOT_USER1    = 2'h1;
   localparam logic [1:0]  SLOT_USER2    = 2'h2;
   localparam int          NUM_USER      = 2;
   // sequencer sets and stored record
   localparam int          NUM_SETS      = 32;
   localparam int          IDX_W         = 5;
   localparam int          FFC_W         = 4;
   localparam logic [3:0]  FFC_MAX       = 4'hF;
   localparam logic [5:0]  COUNT_MIN     = 6'h01;
   localparam logic [5:0]  COUNT_MAX     = 6'h20;
   localparam int          ENTRY_W       = 11;
   localparam int          NUM_ENTRY     = 33;
   localparam logic [5:0]  HDR_IDX       = 6'h20;
   localparam int          HDR_FFC_LSB   = 0;
   localparam int          HDR_CNT_LSB   = 4;
   localparam int          HDR_EN_BIT    = 9;
   localparam int          HDR_TRIG_BIT  = 10;
   localparam logic [10:0] FACTORY_HDR   = 11'h000;
   localparam logic [3:0]  FACTORY_FFC   = 4'h0;
   localparam logic [1:0]  RST_DFLT      = 2'h0;
   // serial channel figures kept for reference; commands arrive over the register bus
   localparam int          CLK_HZ        = 125_000_000;
   localparam int          BAUD_BPS      = 115_200;
   localparam int          BAUD_CYC      = CLK_HZ / BAUD_BPS;

   typedef enum logic [1:0] {
      ST_BOOT = 2'b00,
      ST_LOAD = 2'b01,
      ST_SAVE = 2'b10,
      ST_IDLE = 2'b11
   } ucs_state_t;
endpackage : ucs_pkg

// ---- hw/ucs_store.sv ----
`timescale 1ns/100ps
module ucs_store
   import ucs_pkg::*;
(
   // clock
   input wire logic     aclk,
   // controller side
   ucs_store_if.store   st
);
   // no reset on purpose: contents model flash and survive aresetn
   logic [ENTRY_W-1:0] user_mem [NUM_USER][NUM_ENTRY] = '{default: '0};
   logic [1:0]         dflt_q = RST_DFLT;
   logic [ENTRY_W-1:0] fact_word;

   always_comb begin
      fact_word = (st.idx == HDR_IDX) ? FACTORY_HDR : {7'h00, FACTORY_FFC};
   end

   // factory record is constant, reads only
   assign st.rdata    = (st.slot == SLOT_USER1) ? user_mem[0][st.idx] :
                        (st.slot == SLOT_USER2) ? user_mem[1][st.idx] : fact_word;
   assign st.dflt_sel = dflt_q;

   always_ff @(posedge aclk) begin
      if (st.we && st.slot == SLOT_USER1) begin
         user_mem[0][st.idx] <= st.wdata;
      end
      if (st.we && st.slot == SLOT_USER2) begin
         user_mem[1][st.idx] <= st.wdata;
      end
      if (st.dflt_we) begin
         dflt_q <= st.dflt_wdata;
      end
   end
endmodule : ucs_store

// ---- hw/ucs_store_if.sv ----
`timescale 1ns/100ps
interface ucs_store_if;
   import ucs_pkg::*;
   logic [1:0]         slot;
   logic [5:0]         idx;
   logic               we;
   logic [ENTRY_W-1:0] wdata;
   logic [ENTRY_W-1:0] rdata;
   logic               dflt_we;
   logic [1:0]         dflt_wdata;
   logic [1:0]         dflt_sel;
   modport ctrl  (output slot, idx, we, wdata, dflt_we, dflt_wdata, input rdata, dflt_sel);
   modport store (input slot, idx, we, wdata, dflt_we, dflt_wdata, output rdata, dflt_sel);
endinterface : ucs_store_if
